// >>> core/fpc_top.sv
// flash program control block with apb register access
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module fpc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dev_reset,
    output logic flash_start,
    output logic [3:0] flash_op,
    input wire logic flash_done,
    input wire logic flash_fail,
    input wire logic target_protected,
    input wire logic any_page_protected,
    input wire logic low_voltage_sense,
    output logic lvd_enable,
    output logic irq
);
    // ==========================================================
    // state
    // ==========================================================
    logic trigger;
    logic write_arm;
    logic op_fail_flag;
    logic low_voltage_error;
    logic low_voltage_active;
    logic [3:0] op_select;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [2:0] irq_event;
    fpc_pkg::fpc_state_type st;
    fpc_pkg::fpc_unlock_type unlock;
    logic wr_en;
    logic rd_en;
    logic wr_ctrl;
    logic wr_key;
    logic wr_stat;
    logic wr_mask;
    logic mapped;
    logic accept;
    logic [31:0] next_rdata;

    // true for the codes that drive the flash array
    function automatic logic is_flash_op(input logic [3:0] code);
        is_flash_op = (code == fpc_pkg::op_word)
            || (code == fpc_pkg::op_row)
            || (code == fpc_pkg::op_page)
            || (code == fpc_pkg::op_array);
    endfunction

    // true for the codes that do nothing
    function automatic logic is_nop(input logic [3:0] code);
        is_nop = (code == fpc_pkg::op_nop0)
            || (code == fpc_pkg::op_nop2)
            || (code == fpc_pkg::op_nop6);
    endfunction

    // ==========================================================
    // apb decode
    // ==========================================================
    // zero wait states; errors on unmapped addresses
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    always_comb begin
        mapped = 1'b1;
        if (paddr == fpc_pkg::addr_ctrl) begin
            mapped = 1'b1;
        end else if (paddr == fpc_pkg::addr_key) begin
            mapped = 1'b1;
        end else if (paddr == fpc_pkg::addr_irq_stat) begin
            mapped = 1'b1;
        end else if (paddr == fpc_pkg::addr_irq_mask) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end
    assign pslverr = psel && penable && !mapped;
    assign wr_ctrl = wr_en && (paddr == fpc_pkg::addr_ctrl);
    assign wr_key = wr_en && (paddr == fpc_pkg::addr_key);
    assign wr_stat = wr_en && (paddr == fpc_pkg::addr_irq_stat);
    assign wr_mask = wr_en && (paddr == fpc_pkg::addr_irq_mask);

    // read data, latched in the setup cycle
    always_comb begin
        next_rdata = 32'h00000000; // see RULE14
        if (paddr == fpc_pkg::addr_ctrl) begin
            next_rdata[fpc_pkg::bit_trigger] = trigger;
            next_rdata[fpc_pkg::bit_arm] = write_arm;
            next_rdata[fpc_pkg::bit_fail] = op_fail_flag;
            next_rdata[fpc_pkg::bit_lverr] = low_voltage_error;
            next_rdata[fpc_pkg::bit_lvact] = low_voltage_active;
            next_rdata[fpc_pkg::op_msb:fpc_pkg::op_lsb] = op_select;
        end else if (paddr == fpc_pkg::addr_irq_stat) begin
            next_rdata[fpc_pkg::irq_w-1:0] = irq_stat;
        end else if (paddr == fpc_pkg::addr_irq_mask) begin
            next_rdata[fpc_pkg::irq_w-1:0] = irq_mask;
        end else begin
            next_rdata = 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            prdata <= next_rdata;
        end
    end

    // ==========================================================
    // unlock sequence
    // ==========================================================
    // any completed access that is not the next key step relocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock <= fpc_pkg::fpc_locked;
        end else if (psel && penable) begin
            if (wr_key && pwdata == fpc_pkg::key_first) begin
                unlock <= fpc_pkg::fpc_key1;
            end else if (wr_key && pwdata == fpc_pkg::key_second
                && unlock == fpc_pkg::fpc_key1) begin
                unlock <= fpc_pkg::fpc_open;
            end else begin
                unlock <= fpc_pkg::fpc_locked;
            end
        end
    end

    // trigger write is taken only when armed and just unlocked
    assign accept = wr_ctrl && pwdata[fpc_pkg::bit_trigger]
        && write_arm && unlock == fpc_pkg::fpc_open
        && st == fpc_pkg::fpc_idle; // see RULE1

    // ==========================================================
    // control fields
    // ==========================================================
    // write arm, the only field cleared by device reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_arm <= 1'b0;
        end else if (dev_reset) begin
            write_arm <= 1'b0; // see RULE3
        end else if (wr_ctrl) begin
            write_arm <= pwdata[fpc_pkg::bit_arm];
        end
    end

    // operation select, writable only while disarmed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_select <= fpc_pkg::op_reset;
        end else if (wr_ctrl && !write_arm && !dev_reset) begin
            op_select <= pwdata[fpc_pkg::op_msb:fpc_pkg::op_lsb]; // see RULE8
        end
    end

    // ==========================================================
    // operation sequencer
    // ==========================================================
    // run waits for the array; finish covers no-op and refused ops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= fpc_pkg::fpc_idle;
            trigger <= 1'b0;
            flash_start <= 1'b0;
            flash_op <= fpc_pkg::op_reset;
        end else begin
            flash_start <= 1'b0;
            case (st)
                fpc_pkg::fpc_idle: begin
                    if (accept) begin
                        trigger <= 1'b1; // see RULE2
                        flash_op <= op_select;
                        if (is_flash_op(op_select) && !((op_select
                            == fpc_pkg::op_array) ? any_page_protected
                            : target_protected)) begin
                            st <= fpc_pkg::fpc_run; // see RULE11 RULE12
                            flash_start <= 1'b1; // see RULE9 RULE10
                        end else begin
                            st <= fpc_pkg::fpc_finish; // see RULE13
                        end
                    end
                end
                fpc_pkg::fpc_run: begin
                    if (flash_done) begin
                        st <= fpc_pkg::fpc_idle;
                        trigger <= 1'b0; // see RULE2
                    end
                end
                fpc_pkg::fpc_finish: begin
                    st <= fpc_pkg::fpc_idle;
                    trigger <= 1'b0;
                end
                default: begin
                    st <= fpc_pkg::fpc_idle;
                    trigger <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // status flags
    // ==========================================================
    // failure flag: set on bad end, refused op or reserved code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_fail_flag <= 1'b0;
        end else if (st == fpc_pkg::fpc_run && flash_done) begin
            if (flash_fail || low_voltage_error) begin
                op_fail_flag <= 1'b1; // see RULE5
            end
        end else if (st == fpc_pkg::fpc_finish) begin
            if (flash_op == fpc_pkg::op_nop0) begin
                op_fail_flag <= 1'b0; // see RULE15
            end else if (!is_nop(flash_op)) begin
                op_fail_flag <= 1'b1; // see RULE5
            end
        end
    end

    // low voltage error: sticky, cleared with the failure flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_voltage_error <= 1'b0;
        end else if (write_arm && low_voltage_sense
            && st == fpc_pkg::fpc_run) begin
            low_voltage_error <= 1'b1; // see RULE6
        end else if (st == fpc_pkg::fpc_finish
            && flash_op == fpc_pkg::op_nop0) begin
            low_voltage_error <= 1'b0;
        end
    end

    // low voltage status follows the detector while enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_voltage_active <= 1'b0;
        end else begin
            low_voltage_active <= write_arm && low_voltage_sense; // see RULE7
        end
    end

    assign lvd_enable = write_arm; // see RULE4

    // ==========================================================
    // interrupts
    // ==========================================================
    assign irq_event[fpc_pkg::irq_done] =
        st != fpc_pkg::fpc_idle && trigger
        && (st == fpc_pkg::fpc_finish || flash_done);
    assign irq_event[fpc_pkg::irq_fail] =
        (st == fpc_pkg::fpc_run && flash_done
        && (flash_fail || low_voltage_error))
        || (st == fpc_pkg::fpc_finish && !is_nop(flash_op));
    assign irq_event[fpc_pkg::irq_lverr] = write_arm
        && low_voltage_sense && st == fpc_pkg::fpc_run
        && !low_voltage_error;

    // sticky status, write one to clear, a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= fpc_pkg::irq_reset;
        end else if (wr_stat) begin
            irq_stat <= (irq_stat & ~pwdata[fpc_pkg::irq_w-1:0])
                | irq_event;
        end else begin
            irq_stat <= irq_stat | irq_event;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= fpc_pkg::irq_reset;
        end else if (wr_mask) begin
            irq_mask <= pwdata[fpc_pkg::irq_w-1:0];
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ==========================================================
    // assertions
    // ==========================================================
    property p_trig_gate;
        @(posedge pclk) disable iff (!presetn)
        $rose(trigger) |-> $past(write_arm)
            && $past(unlock) == fpc_pkg::fpc_open;
    endproperty
    a_trig_gate: assert property (p_trig_gate) // see RULE1
        else $error("trigger set without arm and unlock");

    property p_trig_idle;
        @(posedge pclk) disable iff (!presetn)
        (st == fpc_pkg::fpc_idle) == !trigger;
    endproperty
    a_trig_idle: assert property (p_trig_idle) // see RULE2
        else $error("trigger does not match activity");

    property p_dev_reset;
        @(posedge pclk) disable iff (!presetn)
        dev_reset |=> !write_arm && $stable(op_select);
    endproperty
    a_dev_reset: assert property (p_dev_reset) // see RULE3
        else $error("device reset effect wrong");

    property p_lvd_off;
        @(posedge pclk) disable iff (!presetn)
        !write_arm |=> !low_voltage_active;
    endproperty
    a_lvd_off: assert property (p_lvd_off) // see RULE4
        else $error("detector active while disarmed");

    property p_fail_set;
        @(posedge pclk) disable iff (!presetn)
        st == fpc_pkg::fpc_run && flash_done && flash_fail
            |=> op_fail_flag && !trigger;
    endproperty
    a_fail_set: assert property (p_fail_set) // see RULE5
        else $error("failure not flagged");

    property p_lverr_armed;
        @(posedge pclk) disable iff (!presetn)
        $rose(low_voltage_error) |-> $past(write_arm);
    endproperty
    a_lverr_armed: assert property (p_lverr_armed) // see RULE6
        else $error("low voltage error while disarmed");

    property p_lvact;
        @(posedge pclk) disable iff (!presetn)
        write_arm && low_voltage_sense && !dev_reset
            ##1 write_arm |-> low_voltage_active;
    endproperty
    a_lvact: assert property (p_lvact) // see RULE7
        else $error("low voltage status missed");

    property p_opsel_hold;
        @(posedge pclk) disable iff (!presetn)
        wr_ctrl && write_arm |=> $stable(op_select);
    endproperty
    a_opsel_hold: assert property (p_opsel_hold) // see RULE8
        else $error("op select changed while armed");

    property p_start_code;
        @(posedge pclk) disable iff (!presetn)
        flash_start |-> is_flash_op(flash_op)
            ##1 st == fpc_pkg::fpc_run;
    endproperty
    a_start_code: assert property (p_start_code) // see RULE9
        else $error("flash started with a bad code");

    property p_nop_clear;
        @(posedge pclk) disable iff (!presetn)
        st == fpc_pkg::fpc_finish && flash_op == fpc_pkg::op_nop0
            |=> !op_fail_flag && !low_voltage_error;
    endproperty
    a_nop_clear: assert property (p_nop_clear) // see RULE15
        else $error("no-op cycle did not clear errors");

    property p_rsv_zero;
        @(posedge pclk) disable iff (!presetn)
        rd_en && paddr == fpc_pkg::addr_ctrl
            |=> prdata[31:16] == 16'h0000 && prdata[10:4] == 7'h00;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) // see RULE14
        else $error("unimplemented bits not zero");
endmodule

// >>> core/fpc_pkg.sv
// constants for the flash program control block
// Summary of operation
// RULE1 - the trigger bit is taken only while armed and right after unlock.
// RULE2 - setting the trigger starts the operation and it clears when done.
// RULE3 - a device reset clears only the write arm bit.
// RULE4 - arming permits trigger writes and enables the voltage detector.
// RULE5 - the failure flag is set when an operation does not complete well.
// RULE6 - the low voltage error sets on low supply while programming armed.
// RULE7 - the low voltage status follows an active event while armed.
// RULE8 - the operation select field is writable only while disarmed.
// RULE9 - code 0001 programs one word unless it is protected.
// RULE10 - code 0011 programs one row unless it is protected.
// RULE11 - code 0100 erases one page unless it is protected.
// RULE12 - code 0101 erases the array only if no page is protected.
// RULE13 - codes 0000, 0010 and 0110 do nothing; higher codes are reserved.
// RULE14 - all unimplemented bits read as zero.
// RULE15 - a triggered code 0000 cycle clears the failure flag.
// RULE16 - software unlocks with two key writes just before the trigger.
// RULE17 - software sets address and operation before arming.
package fpc_pkg;
    // register byte addresses
    localparam logic [7:0] addr_ctrl = 8'h00;
    localparam logic [7:0] addr_key = 8'h04;
    localparam logic [7:0] addr_irq_stat = 8'h08;
    localparam logic [7:0] addr_irq_mask = 8'h0c;
    // control register fields
    localparam int bit_trigger = 15;
    localparam int bit_arm = 14;
    localparam int bit_fail = 13;
    localparam int bit_lverr = 12;
    localparam int bit_lvact = 11;
    localparam int op_lsb = 0;
    localparam int op_msb = 3;
    // operation codes
    localparam logic [3:0] op_nop0 = 4'h0;
    localparam logic [3:0] op_word = 4'h1;
    localparam logic [3:0] op_nop2 = 4'h2;
    localparam logic [3:0] op_row = 4'h3;
    localparam logic [3:0] op_page = 4'h4;
    localparam logic [3:0] op_array = 4'h5;
    localparam logic [3:0] op_nop6 = 4'h6;
    // unlock keys, values arbitrary
    localparam logic [31:0] key_first = 32'h11223344;
    localparam logic [31:0] key_second = 32'h55667788;
    // interrupt status bits
    localparam int irq_done = 0;
    localparam int irq_fail = 1;
    localparam int irq_lverr = 2;
    localparam int irq_w = 3;
    // reset values
    localparam logic [3:0] op_reset = 4'h0;
    localparam logic [2:0] irq_reset = 3'h0;
    typedef enum logic [1:0] {
        fpc_idle, fpc_run, fpc_finish
    } fpc_state_type;
    typedef enum logic [1:0] {
        fpc_locked, fpc_key1, fpc_open
    } fpc_unlock_type;
endpackage

// >>> sim/fpc_flash_model.sv
// behavioural model of the program flash array behind the block
`timescale 1ns/1ns
module fpc_flash_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic flash_start,
    input wire logic fail_cmd,
    input wire logic [3:0] lat,
    output logic flash_done,
    output logic flash_fail
);
    int cnt;
    logic busy;
    // count out the latency after a start, then pulse done once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            cnt <= 0;
            flash_done <= 1'b0;
            flash_fail <= 1'b0;
        end else begin
            flash_done <= 1'b0;
            flash_fail <= ~flash_fail; // meaningless outside done
            if (flash_start) begin
                busy <= 1'b1;
                cnt <= lat;
            end else if (busy && cnt == 0) begin
                busy <= 1'b0;
                flash_done <= 1'b1;
                flash_fail <= fail_cmd;
            end else if (busy) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// >>> sim/tb_top.sv
// self-checking testbench for the flash program control block
`timescale 1ns/1ns
module tb_top;
    // ==========
    // signals
    localparam logic [7:0] a_ctl = fpc_pkg::addr_ctrl;
    localparam logic [7:0] a_key = fpc_pkg::addr_key;
    localparam logic [7:0] a_st = fpc_pkg::addr_irq_stat;
    localparam logic [7:0] a_msk = fpc_pkg::addr_irq_mask;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic dev_reset, flash_start, flash_done, flash_fail, lvd_enable;
    logic tprot, aprot, lv_sense, mfail, err;
    logic [7:0] paddr;
    logic [3:0] flash_op, lat, last_op;
    logic [31:0] pwdata, prdata, rd;
    int err_count, total_checks, starts, s0;
    typedef struct {
        logic [3:0] op;
        logic tp, ap, mf, st, fl;
    } fpc_row_type;
    // code, target and page protection, array fault, start, fail flag
    fpc_row_type rows [16] = '{
        '{1, 0, 0, 0, 1, 0}, '{3, 0, 1, 1, 1, 1}, '{0, 0, 0, 0, 0, 0},
        '{4, 1, 0, 0, 0, 1}, '{2, 0, 0, 0, 0, 1}, '{6, 0, 0, 0, 0, 1},
        '{0, 0, 0, 0, 0, 0}, '{5, 0, 1, 0, 0, 1}, '{0, 1, 1, 0, 0, 0},
        '{5, 1, 0, 0, 1, 0}, '{7, 0, 0, 0, 0, 1}, '{0, 0, 0, 0, 0, 0},
        '{15, 0, 0, 0, 0, 1}, '{1, 1, 0, 0, 0, 1}, '{0, 0, 0, 0, 0, 0},
        '{4, 0, 0, 0, 1, 0}};
    fpc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dev_reset(dev_reset),
        .flash_start(flash_start), .flash_op(flash_op),
        .flash_done(flash_done), .flash_fail(flash_fail),
        .target_protected(tprot), .any_page_protected(aprot),
        .low_voltage_sense(lv_sense), .lvd_enable(lvd_enable),
        .irq(irq));
    fpc_flash_model flash (.pclk(pclk), .presetn(presetn),
        .flash_start(flash_start), .fail_cmd(mfail), .lat(lat),
        .flash_done(flash_done), .flash_fail(flash_fail));
    // ==========
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // one apb transfer; read data and error taken at the pready edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // select while disarmed, arm, unlock, then trigger
    task automatic start_op(input logic [3:0] op);
        apb(1, a_ctl, {28'h0, op});
        apb(1, a_ctl, {28'h0, op});
        apb(1, a_ctl, {16'h0, 4'h4, 8'h0, op});
        apb(1, a_key, fpc_pkg::key_first);
        apb(1, a_key, fpc_pkg::key_second);
        apb(1, a_ctl, 32'h0000_c000);
    endtask
    // poll until the trigger bit reads back clear
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(0, a_ctl, 32'h0);
            n++;
        end while (rd[15] !== 1'b0 && n < 40);
        if (n >= 40) begin
            err_count++;
            complete_run();
        end
    endtask
    // ==========
    // clock, start monitor and test sequence
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // count start pulses and remember the code they carried
    always @(posedge pclk) begin
        if (flash_start === 1'b1) begin
            starts++;
            last_op = flash_op;
        end
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {dev_reset, tprot, aprot, lv_sense, mfail} = 5'h00;
        lat = 4'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, a_ctl, 32'h0);
        check(rd, 32'h0);
        apb(0, a_st, 32'h0);
        check(rd, 32'h0);
        apb(1, a_ctl, 32'hffff_b8ff);
        apb(0, a_ctl, 32'h0);
        check(rd, 32'h0000_000f);
        check(starts, 0);
        $display("reset and field test done");
        // table of codes with protection and array faults
        for (int i = 0; i < 16; i++) begin
            s0 = starts;
            tprot <= rows[i].tp;
            aprot <= rows[i].ap;
            mfail <= rows[i].mf;
            lat <= 4'(i % 4);
            start_op(rows[i].op);
            wait_idle();
            check(starts - s0, rows[i].st);
            check(rd[13], rows[i].fl);
            check(rd[14], 1'b1);
            if (rows[i].st) begin
                check(last_op, rows[i].op);
            end
        end
        $display("operation table done");
        apb(1, a_ctl, 32'h0000_0003);
        apb(1, a_ctl, 32'h0000_4003);
        apb(1, a_ctl, 32'h0000_4001);
        apb(0, a_ctl, 32'h0);
        check(rd, 32'h0000_4003);
        check(lvd_enable, 1'b1);
        @(posedge pclk);
        dev_reset <= 1'b1;
        @(posedge pclk);
        dev_reset <= 1'b0;
        apb(0, a_ctl, 32'h0);
        check(rd, 32'h0000_0003);
        check(lvd_enable, 1'b0);
        $display("arm and device reset test done");
        s0 = starts;
        apb(1, a_ctl, 32'h0000_4003);
        apb(1, a_key, fpc_pkg::key_first);
        apb(1, a_ctl, 32'h0000_c003);
        apb(0, a_ctl, 32'h0);
        check(rd, 32'h0000_4003);
        check(starts - s0, 0);
        $display("locked trigger test done");
        apb(1, a_ctl, 32'h0);
        apb(1, a_st, 32'h7);
        apb(1, a_msk, 32'h7);
        tprot <= 1'b0;
        mfail <= 1'b0;
        lv_sense <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(0, a_ctl, 32'h0);
        check(rd[11], 1'b0);
        start_op(4'h1);
        wait_idle();
        check(rd, 32'h0000_7801);
        apb(0, a_st, 32'h0);
        check(rd, 32'h7);
        check(irq, 1'b1);
        apb(1, a_msk, 32'h0);
        apb(0, a_st, 32'h0);
        check(irq, 1'b0);
        apb(1, a_msk, 32'h7);
        apb(1, a_st, 32'h7);
        apb(0, a_st, 32'h0);
        check(rd, 32'h0);
        check(irq, 1'b0);
        lv_sense <= 1'b0;
        repeat (3) @(posedge pclk);
        apb(0, a_ctl, 32'h0);
        check(rd[11], 1'b0);
        $display("low voltage and interrupt test done");
        apb(1, 8'h40, 32'hffff_ffff);
        check(err, 1'b1);
        apb(0, 8'h40, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        apb(0, a_key, 32'h0);
        check(err, 1'b0);
        check(rd, 32'h0);
        $display("unmapped access test done");
        complete_run();
    end
endmodule
